// ===== src/event_status_consts.svh
// Register offsets, field positions, reset values and timing counts of the event flag bank
// Contract
// - Each flag latches on its event and clears only when one is written to it.
// - System flag bit 7 sets when first reference plus 4% exceeds the second.
// - System flag bit 6 sets when first reference minus 4% is below the second.
// - System bit 5 shows enable-pin wake-up as one, power-on wake-up as zero.
// - System bit 3 sets on sync clock fault, bit 2 on enable-pin event.
// - System bit 1 sets on output voltage config fault, bit 0 on supervision fault.
// - MCU fault bit 7 hard reset, bit 6 soft reset, bit 3 watchdog fault.
// - MCU fault bit 0 sets on an init timer error.
// - MCU warning bit 3 sets on a missed watchdog trigger; other bits read zero.
// - Serial error bit 3 sets when select stays low longer than 2 ms.
// - Serial error bit 1 sets when a frame has other than 16 clock cycles.
// - Serial error bit 0 sets on a frame parity failure.
// - Serial error bit 2 sets when a frame addresses an invalid register.
// - Serial error bit 4 sets on a wrong lock or unlock sequence.
// - Serial error bit 5 sets on an erroneous device control access.
// - Serial error bit 6 sets on an erroneous secondary buck access; bit 7 unused.
// - A rising flag in this bank sets its global summary bit, on the edge only.
// - Clearing bank flags and clearing summary bits never affect each other.
`ifndef EVENT_STATUS_CONSTS_SVH
`define EVENT_STATUS_CONSTS_SVH

`define OFS_GLOBAL_SUMMARY 8'h1A
`define OFS_SYSTEM_INT 8'h1C
`define OFS_MCU_FAULT 8'h1D
`define OFS_MCU_WARN 8'h1E
`define OFS_SERIAL_ERR 8'h1F

`define RST_FLAGS 8'h00

`define MASK_SYSTEM_INT 8'hEF
`define MASK_MCU_FAULT 8'hC9
`define MASK_MCU_WARN 8'h08
`define MASK_SERIAL_ERR 8'h7F
`define MASK_GLOBAL_SUMMARY 8'h07

`define SYS_REFV_HIGH 7
`define SYS_REFV_LOW 6
`define SYS_WAKE_SRC 5
`define SYS_SYNC_FAULT 3
`define SYS_ENA_EVENT 2
`define SYS_VOUT_CFG 1
`define SYS_SUPV_CFG 0

`define MF_HARD_RESET 7
`define MF_SOFT_RESET 6
`define MF_WDG_FAULT 3
`define MF_INIT_ERR 0

`define MW_WDG_MISS 3

`define SE_BUCK2_ACC 6
`define SE_DEVICE_CONTROL_ACCESS_ERROR_ACC 5
`define SE_LOCK 4
`define SE_DURATION 3
`define SE_ADDR 2
`define SE_LENGTH 1
`define SE_PARITY 0

`define GS_SYS 0
`define GS_MCU 1
`define GS_SPI 2

`define CLK_PERIOD_NS 8
`define SEL_TIME_NS 2000000
`define SEL_DUR_CYCLES ((`SEL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_CLOCKS 5'h10

`endif

// ===== src/event_status_pkg.sv
// Types shared by the event flag bank and its frame checker
package event_status_pkg;

  typedef enum logic [1:0] {
    FRM_IDLE = 2'b01,
    FRM_OPEN = 2'b10
  } frame_state_t;

  typedef struct packed {
    frame_state_t state;
    logic sclk_prev;
    logic [4:0] edge_cnt;
    logic [17:0] dur_cnt;
    logic dur_done;
    logic dur_err;
    logic len_err;
  } checker_state_t;

  typedef struct packed {
    logic [7:0] sys_flags;
    logic [7:0] mcu_fault;
    logic [7:0] mcu_warn;
    logic [7:0] serial_err;
    logic [7:0] summary;
    logic [7:0] rdata;
  } bank_state_t;

endpackage

// ===== src/frame_err_if.sv
// Frame error pulses passed from the frame checker to the flag bank
`timescale 1ns/1ps
interface frame_err_if;
  logic dur_err;
  logic len_err;

  modport src (output dur_err, output len_err);
  modport dst (input dur_err, input len_err);
endinterface

// ===== src/frame_checker.sv
// Watches select and serial clock for over-long and wrong-length frames
`timescale 1ns/1ps
`include "event_status_consts.svh"
module frame_checker #(
  parameter int DUR_CYCLES = `SEL_DUR_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Serial link pins
  input wire logic sel_n,
  input wire logic sclk,
  // Error pulses
  frame_err_if.src errs
);

  event_status_pkg::checker_state_t s_q;
  event_status_pkg::checker_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.sclk_prev = sclk;
    s_d.dur_err = 1'b0;
    s_d.len_err = 1'b0;
    unique case (s_q.state)
      event_status_pkg::FRM_IDLE:
      begin
        if (!sel_n)
        begin
          s_d.state = event_status_pkg::FRM_OPEN;
          s_d.edge_cnt = 5'h00;
          s_d.dur_cnt = 18'h0_0001;
          s_d.dur_done = 1'b0;
        end
      end
      event_status_pkg::FRM_OPEN:
      begin
        if (sclk && !s_q.sclk_prev && s_q.edge_cnt != 5'h1F)
        begin
          s_d.edge_cnt = s_q.edge_cnt + 5'h01;
        end
        // Counter stops once fired, so one long frame gives one error
        if (!s_q.dur_done)
        begin
          s_d.dur_cnt = s_q.dur_cnt + 18'h0_0001;
          // Select must still be low here, so exactly 2 ms is not yet an error
          if (s_q.dur_cnt >= 18'(DUR_CYCLES) && !sel_n)
          begin
            s_d.dur_err = 1'b1;
            s_d.dur_done = 1'b1;
          end
        end
        if (sel_n)
        begin
          s_d.state = event_status_pkg::FRM_IDLE;
          s_d.len_err = (s_q.edge_cnt != `FRAME_CLOCKS);
        end
      end
      default:
      begin
        s_d.state = event_status_pkg::FRM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '{state: event_status_pkg::FRM_IDLE, sclk_prev: 1'b0, edge_cnt: 5'h00,
               dur_cnt: 18'h0_0000, dur_done: 1'b0, dur_err: 1'b0, len_err: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign errs.dur_err = s_q.dur_err;
  assign errs.len_err = s_q.len_err;

endmodule

// ===== src/event_status_flags.sv
// Sticky event flag bank with write-one-to-clear access and global summary bits
`timescale 1ns/1ps
`include "event_status_consts.svh"
module event_status_flags #(
  parameter int DUR_CYCLES = `SEL_DUR_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register access port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // System events
  input wire logic refv_high_warning,
  input wire logic refv_low_warning,
  input wire logic wake_source_flag,
  input wire logic sync_fault,
  input wire logic enable_pin_event,
  input wire logic vout_config_fault,
  input wire logic supervision_config_fault,
  // Microcontroller events
  input wire logic hard_reset_event,
  input wire logic soft_reset_event,
  input wire logic window_watchdog_fault,
  input wire logic init_timer_error,
  input wire logic watchdog_missed_trigger,
  // Serial protocol events
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic parity_error,
  input wire logic invalid_address_error,
  input wire logic lock_sequence_error,
  input wire logic device_control_access_error,
  input wire logic secondary_buck_ctrl_access_error,
  // Flag views
  output logic [7:0] global_summary_flags,
  output logic [7:0] system_interrupt_flags,
  output logic [7:0] mcu_fault_flags,
  output logic [7:0] mcu_warning_flags,
  output logic [7:0] serial_error_flags
);

  frame_err_if ferr ();

  frame_checker #(
    .DUR_CYCLES(DUR_CYCLES)
  ) u_checker (
    .mclk(mclk),
    .resetn(resetn),
    .sel_n(sel_n),
    .sclk(sclk),
    .errs(ferr)
  );

  event_status_pkg::bank_state_t s_q;
  event_status_pkg::bank_state_t s_d;

  // Next value of one rw1c byte; set wins over a clear in the same cycle
  function automatic logic [7:0] w1c_next(input logic [7:0] cur, input logic [7:0] ev,
                                          input logic clr, input logic [7:0] wdata,
                                          input logic [7:0] mask);
    logic [7:0] kept;
    kept = clr ? (cur & ~wdata) : cur;
    return (kept | ev) & mask;
  endfunction

  // Any flag that was low and is now high
  function automatic logic rose(input logic [7:0] prev, input logic [7:0] nxt);
    return |(nxt & ~prev);
  endfunction

  logic [7:0] ev_sys;
  logic [7:0] ev_mf;
  logic [7:0] ev_mw;
  logic [7:0] ev_se;
  logic [7:0] gs_rise;
  logic wr_sys;
  logic wr_mf;
  logic wr_mw;
  logic wr_se;
  logic wr_gs;
  logic addr_ok;

  always_comb
  begin
    ev_sys = 8'h00;
    ev_sys[`SYS_REFV_HIGH] = refv_high_warning;
    ev_sys[`SYS_REFV_LOW] = refv_low_warning;
    // Only an enable-pin wake-up raises it; power-on wake-up leaves zero
    ev_sys[`SYS_WAKE_SRC] = wake_source_flag;
    ev_sys[`SYS_SYNC_FAULT] = sync_fault;
    ev_sys[`SYS_ENA_EVENT] = enable_pin_event;
    ev_sys[`SYS_VOUT_CFG] = vout_config_fault;
    ev_sys[`SYS_SUPV_CFG] = supervision_config_fault;

    ev_mf = 8'h00;
    ev_mf[`MF_HARD_RESET] = hard_reset_event;
    ev_mf[`MF_SOFT_RESET] = soft_reset_event;
    ev_mf[`MF_WDG_FAULT] = window_watchdog_fault;
    ev_mf[`MF_INIT_ERR] = init_timer_error;

    ev_mw = 8'h00;
    ev_mw[`MW_WDG_MISS] = watchdog_missed_trigger;

    ev_se = 8'h00;
    ev_se[`SE_BUCK2_ACC] = secondary_buck_ctrl_access_error;
    ev_se[`SE_DEVICE_CONTROL_ACCESS_ERROR_ACC] = device_control_access_error;
    ev_se[`SE_LOCK] = lock_sequence_error;
    ev_se[`SE_DURATION] = ferr.dur_err;
    ev_se[`SE_ADDR] = invalid_address_error;
    ev_se[`SE_LENGTH] = ferr.len_err;
    ev_se[`SE_PARITY] = parity_error;
  end

  always_comb
  begin
    wr_sys = reg_wr && (reg_addr == `OFS_SYSTEM_INT);
    wr_mf = reg_wr && (reg_addr == `OFS_MCU_FAULT);
    wr_mw = reg_wr && (reg_addr == `OFS_MCU_WARN);
    wr_se = reg_wr && (reg_addr == `OFS_SERIAL_ERR);
    wr_gs = reg_wr && (reg_addr == `OFS_GLOBAL_SUMMARY);
    addr_ok = (reg_addr == `OFS_SYSTEM_INT) || (reg_addr == `OFS_MCU_FAULT) ||
              (reg_addr == `OFS_MCU_WARN) || (reg_addr == `OFS_SERIAL_ERR) ||
              (reg_addr == `OFS_GLOBAL_SUMMARY);
  end

  always_comb
  begin
    s_d = s_q;
    // Bank clears come only from bank writes, never from summary writes
    s_d.sys_flags = w1c_next(s_q.sys_flags, ev_sys, wr_sys, reg_wdata,
                             `MASK_SYSTEM_INT);
    s_d.mcu_fault = w1c_next(s_q.mcu_fault, ev_mf, wr_mf, reg_wdata, `MASK_MCU_FAULT);
    s_d.mcu_warn = w1c_next(s_q.mcu_warn, ev_mw, wr_mw, reg_wdata, `MASK_MCU_WARN);
    s_d.serial_err = w1c_next(s_q.serial_err, ev_se, wr_se, reg_wdata,
                              `MASK_SERIAL_ERR);

    // Summary follows the rising edge of a flag, so a held flag cleared
    // in the summary does not re-arm it until the flag itself falls and rises
    gs_rise = 8'h00;
    gs_rise[`GS_SYS] = rose(s_q.sys_flags, s_d.sys_flags);
    gs_rise[`GS_MCU] = rose(s_q.mcu_fault, s_d.mcu_fault) ||
                       rose(s_q.mcu_warn, s_d.mcu_warn);
    gs_rise[`GS_SPI] = rose(s_q.serial_err, s_d.serial_err);
    s_d.summary = w1c_next(s_q.summary, gs_rise, wr_gs, reg_wdata,
                           `MASK_GLOBAL_SUMMARY);

    // Read data is captured before this cycle's update takes effect
    s_d.rdata = s_q.rdata;
    if (reg_rd)
    begin
      unique case (1'b1)
        reg_addr == `OFS_SYSTEM_INT: s_d.rdata = s_q.sys_flags;
        reg_addr == `OFS_MCU_FAULT: s_d.rdata = s_q.mcu_fault;
        reg_addr == `OFS_MCU_WARN: s_d.rdata = s_q.mcu_warn;
        reg_addr == `OFS_SERIAL_ERR: s_d.rdata = s_q.serial_err;
        reg_addr == `OFS_GLOBAL_SUMMARY: s_d.rdata = s_q.summary;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '{sys_flags: `RST_FLAGS, mcu_fault: `RST_FLAGS, mcu_warn: `RST_FLAGS,
               serial_err: `RST_FLAGS, summary: `RST_FLAGS, rdata: 8'h00};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign reg_hit = addr_ok && (reg_rd || reg_wr);
  assign global_summary_flags = s_q.summary;
  assign system_interrupt_flags = s_q.sys_flags;
  assign mcu_fault_flags = s_q.mcu_fault;
  assign mcu_warning_flags = s_q.mcu_warn;
  assign serial_error_flags = s_q.serial_err;

endmodule

// ===== testbench/event_status_flags_checker.sv
// Port assertions for the event flag bank
`timescale 1ns/1ps
`include "event_status_consts.svh"
module event_status_flags_checker #(
  parameter int DUR_CYCLES = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  // Events
  input wire logic refv_high_warning,
  input wire logic enable_pin_event,
  input wire logic hard_reset_event,
  input wire logic watchdog_missed_trigger,
  input wire logic parity_error,
  // Flag views
  input wire logic [7:0] global_summary_flags,
  input wire logic [7:0] system_interrupt_flags,
  input wire logic [7:0] mcu_fault_flags,
  input wire logic [7:0] mcu_warning_flags,
  input wire logic [7:0] serial_error_flags
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic clr_par;
  logic clr_sum;
  assign clr_par = reg_wr && reg_addr == `OFS_SERIAL_ERR && reg_wdata[0];
  assign clr_sum = reg_wr && reg_addr == `OFS_GLOBAL_SUMMARY && reg_wdata[2];
  a_refv_high_sets: assert property (refv_high_warning |=> system_interrupt_flags[7])
    else $error("refv high flag not set");
  a_hard_reset_sets: assert property (hard_reset_event |=> mcu_fault_flags[7])
    else $error("hard reset flag not set");
  a_missed_trig_sets: assert property (watchdog_missed_trigger |=> mcu_warning_flags[3])
    else $error("missed trigger flag not set");
  a_parity_sticky: assert property (serial_error_flags[0] && !clr_par
    |=> serial_error_flags[0]) else $error("parity flag dropped");
  a_parity_summary: assert property (parity_error && !serial_error_flags[0]
    |=> serial_error_flags[0] && global_summary_flags[2]) else $error("parity or summary not set");
  a_clear_enable: assert property (reg_wr && reg_addr == `OFS_SYSTEM_INT && reg_wdata[2]
    && !enable_pin_event |=> !system_interrupt_flags[2]) else $error("enable flag not cleared");
  a_summary_kept: assert property (global_summary_flags[2] && !clr_sum
    |=> $stable(global_summary_flags[2])) else $error("summary bit dropped");
  a_unused_zero: assert property (mcu_warning_flags[7:4] == 4'h0
    && !serial_error_flags[7] && !system_interrupt_flags[4]
    && mcu_fault_flags[5:4] == 2'h0 && mcu_fault_flags[2:1] == 2'h0)
    else $error("unused bit set");
  a_read_warn: assert property (reg_rd && reg_addr == `OFS_MCU_WARN
    |=> reg_rdata == $past(mcu_warning_flags)) else $error("warning read data wrong");
  a_unmapped_miss: assert property (reg_rd && reg_addr > `OFS_SERIAL_ERR |-> !reg_hit)
    else $error("unmapped address hit");
  cover property (parity_error);
  cover property (clr_sum);
  cover property ($rose(serial_error_flags[3]));
endmodule
bind event_status_flags event_status_flags_checker #(.DUR_CYCLES(DUR_CYCLES)) i_chk (
  .mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_hit,
  .refv_high_warning, .enable_pin_event, .hard_reset_event, .watchdog_missed_trigger,
  .parity_error, .global_summary_flags, .system_interrupt_flags, .mcu_fault_flags,
  .mcu_warning_flags, .serial_error_flags);

// ===== testbench/spi_frame_master.sv
// Serial host model that opens frames with a chosen clock count
`timescale 1ns/1ps
module spi_frame_master (
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic sel_n,
  output logic sclk
);
  initial
  begin
    sel_n = 1'b1;
    sclk = 1'b0;
  end
  // Clock rests low outside frames; select idles a cycle after each frame
  task automatic frame(input int pulses, input int hold);
    @(negedge mclk) sel_n = 1'b0;
    repeat (pulses)
    begin
      @(negedge mclk) sclk = 1'b1;
      @(negedge mclk) sclk = 1'b0;
    end
    repeat (hold) @(negedge mclk);
    @(negedge mclk) sel_n = 1'b1;
    @(negedge mclk);
  endtask
endmodule

// ===== testbench/event_status_flags_tb.sv
// Self-checking bench for the event flag bank
`timescale 1ns/1ps
`include "event_status_consts.svh"
module event_status_flags_tb;
  localparam int SELECT_DURATION_ERROR = 60;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [16:0] ev = 17'h0_0000;
  logic [7:0] reg_rdata, global_summary_flags, system_interrupt_flags;
  logic [7:0] mcu_fault_flags, mcu_warning_flags, serial_error_flags, m, gbit;
  logic reg_hit, sel_n, sclk;
  int fail_count = 0;
  int n_tests = 0;
  logic [7:0] ofs [17] = '{8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h1D, 8'h1D,
    8'h1D, 8'h1D, 8'h1E, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h1F};
  int bitp [17] = '{7, 6, 5, 3, 2, 1, 0, 7, 6, 3, 0, 3, 0, 2, 4, 5, 6};

  always #4 mclk = ~mclk;

  event_status_flags #(.DUR_CYCLES(SELECT_DURATION_ERROR)) i_dut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .refv_high_warning(ev[0]), .refv_low_warning(ev[1]), .wake_source_flag(ev[2]),
    .sync_fault(ev[3]), .enable_pin_event(ev[4]), .vout_config_fault(ev[5]),
    .supervision_config_fault(ev[6]), .hard_reset_event(ev[7]), .soft_reset_event(ev[8]),
    .window_watchdog_fault(ev[9]), .init_timer_error(ev[10]),
    .watchdog_missed_trigger(ev[11]), .sel_n(sel_n), .sclk(sclk), .parity_error(ev[12]),
    .invalid_address_error(ev[13]), .lock_sequence_error(ev[14]),
    .device_control_access_error(ev[15]), .secondary_buck_ctrl_access_error(ev[16]),
    .global_summary_flags(global_summary_flags), .system_interrupt_flags(system_interrupt_flags),
    .mcu_fault_flags(mcu_fault_flags), .mcu_warning_flags(mcu_warning_flags),
    .serial_error_flags(serial_error_flags));

  spi_frame_master i_host (.mclk(mclk), .sel_n(sel_n), .sclk(sclk));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    #1;
    chk("reg_hit", {7'h00, a == 8'h1A || (a >= 8'h1C && a <= 8'h1F)}, {7'h00, reg_hit});
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("reg_rdata", e, reg_rdata);
  endtask

  task automatic pulse(input logic [16:0] v);
    @(negedge mclk);
    ev = v;
    @(negedge mclk);
    ev = 17'h0_0000;
  endtask

  task automatic frame_chk(input int n, input int hold, input logic [7:0] e);
    i_host.frame(n, hold);
    repeat (3) @(negedge mclk);
    chk("serial_error_flags", e, serial_error_flags);
    wr(`OFS_SERIAL_ERR, 8'hFF);
  endtask

  task test_done;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    for (int a = 8'h1A; a <= 8'h20; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 17; i++)
    begin
      m = 8'h01 << bitp[i];
      gbit = (ofs[i] == 8'h1C) ? 8'h01 : (ofs[i] == 8'h1F) ? 8'h04 : 8'h02;
      pulse(17'h0_0001 << i);
      chk("global_summary_flags", gbit, global_summary_flags);
      rd(ofs[i], m);
      wr(ofs[i], ~m);
      rd(ofs[i], m);
      wr(ofs[i], m);
      rd(ofs[i], 8'h00);
      chk("global_summary_flags", gbit, global_summary_flags);
      wr(`OFS_GLOBAL_SUMMARY, gbit);
      chk("global_summary_flags", 8'h00, global_summary_flags);
    end
    // Event and clear in one cycle: the event wins
    fork
      pulse(17'h0_0010);
      wr(`OFS_SYSTEM_INT, 8'h04);
    join
    rd(`OFS_SYSTEM_INT, 8'h04);
    wr(`OFS_SYSTEM_INT, 8'h04);
    wr(`OFS_GLOBAL_SUMMARY, 8'h01);
    // All events at once, then clearing the summary must leave the bank intact
    pulse(17'h1_FFFF);
    chk("system_interrupt_flags", 8'hEF, system_interrupt_flags);
    chk("mcu_fault_flags", 8'hC9, mcu_fault_flags);
    chk("mcu_warning_flags", 8'h08, mcu_warning_flags);
    chk("serial_error_flags", 8'h75, serial_error_flags);
    chk("global_summary_flags", 8'h07, global_summary_flags);
    wr(`OFS_GLOBAL_SUMMARY, 8'hFF);
    rd(`OFS_GLOBAL_SUMMARY, 8'h00);
    rd(`OFS_SYSTEM_INT, 8'hEF);
    rd(`OFS_MCU_FAULT, 8'hC9);
    rd(`OFS_MCU_WARN, 8'h08);
    rd(`OFS_SERIAL_ERR, 8'h75);
    for (int a = 8'h1C; a <= 8'h1F; a++) wr(8'(a), 8'hFF);
    for (int a = 8'h1C; a <= 8'h1F; a++) rd(8'(a), 8'h00);
    // Reset in mid-run drops every flag and the summary
    pulse(17'h1_FFFF);
    @(negedge mclk);
    resetn = 1'b0;
    @(negedge mclk);
    chk("serial_error_flags", 8'h00, serial_error_flags);
    resetn = 1'b1;
    for (int a = 8'h1A; a <= 8'h1F; a++) rd(8'(a), 8'h00);
    frame_chk(16, 0, 8'h00);
    frame_chk(15, 0, 8'h02);
    frame_chk(17, 0, 8'h02);
    frame_chk(16, SELECT_DURATION_ERROR + 20, 8'h08);
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    test_done();
  end
endmodule
